// >>> hw/ctc_pkg.sv
package ctc_pkg;

    // ==================================================================
    // register map (byte addresses on the apb bus)
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] ADDR_COUNT  = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BUFFER = 8'h0c;

    // ==================================================================
    // field positions
    localparam int CTRL_MODE_LSB    = 0;
    localparam int CTRL_STOP_BIT    = 4;
    localparam int CTRL_DEC_BIT     = 5;
    localparam int CTRL_TOG_ON_BIT  = 6;
    localparam int CTRL_TOG_OFF_BIT = 7;
    localparam int CTRL_TOG_RD_BIT  = 8;
    localparam int STATUS_IRQ_BIT   = 0;
    localparam int STATUS_PRE_LSB   = 8;

    // ==================================================================
    // values after reset and counts
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [4:0] PRESC_RST = 5'h1f;
    localparam logic [4:0] PRESC_END = 5'h00;

    // ==================================================================
    // modes
    typedef enum logic [2:0] {
        MODE_IDLE      = 3'b000,
        MODE_EVENT_ONE = 3'b001,
        MODE_EVENT_TWO = 3'b010,
        MODE_TIMER     = 3'b011,
        MODE_PULSE_ONE = 3'b100,
        MODE_PULSE_TWO = 3'b101
    } ctc_mode_type;

    // decoded command strobes from a register write
    typedef struct packed {
        logic         load;
        logic         stop;
        logic         mode_wr;
        ctc_mode_type mode;
        logic         dec;
        logic         tog_on;
        logic         tog_off;
        logic         irq_clr;
        logic [7:0]   data;
    } ctc_cmd_type;

endpackage : ctc_pkg

// >>> hw/ctc_timer_counter.sv
`timescale 1ns/1ps
// Function
// - eight-bit presettable down-counter, modulo the value held in the buffer register
// - software picks source: prescaled pulse, flag one, flag two, or gated pulse
// - count at 01 reloads from buffer, sets interrupt, keeps decrementing
// - preset of zero gives 256 counts before reload and interrupt
// - load writes counter and buffer and clears pending interrupt
// - reading the counter disturbs nothing
// - event mode one: each falling edge of flag one decrements
// - event mode two: each falling edge of flag two decrements
// - timer mode: prescaler steps on pulse rise, each wrap decrements once
// - prescaler held reset outside timer mode and when stopped
// - pulse mode one: pulse rise decrements only while flag one low
// - pulse mode two: pulse rise decrements only while flag two low
// - selected flag returning high halts, clears mode, latches interrupt
// - underflow while flag still low sets interrupt and counting goes on
// - flags stay visible for branch testing in every mode
// - stop command clears the mode and ends all counting except software decrement
// - software decrement counts once; software uses it only when stopped
// - with toggle enabled, q output flips on every count from 01
module ctc_timer_counter (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ctc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      cycle_timing_pulse,
    input  wire logic                      flag_input_one_n,
    input  wire logic                      flag_input_two_n,
    output logic                           flag_one_level,
    output logic                           flag_two_level,
    output logic                           counter_irq,
    output logic                           q_out
);

    // ==================================================================
    // pin synchronisers: a change counts once stages two and three agree
    logic [2:0] pls_sync_q, f1_sync_q, f2_sync_q;
    logic       pls_lvl_q, f1_lvl_q, f2_lvl_q;
    logic       pls_lvl_d, f1_lvl_d, f2_lvl_d;

    // one filter shared by all three pins
    function automatic logic settle(input logic mid, input logic last, input logic held);
        return (mid == last) ? last : held;
    endfunction : settle

    always_comb begin
        pls_lvl_d = settle(pls_sync_q[1], pls_sync_q[2], pls_lvl_q);
        f1_lvl_d  = settle(f1_sync_q[1], f1_sync_q[2], f1_lvl_q);
        f2_lvl_d  = settle(f2_sync_q[1], f2_sync_q[2], f2_lvl_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pls_sync_q <= 3'h0;
            f1_sync_q  <= 3'h7;
            f2_sync_q  <= 3'h7;
            pls_lvl_q  <= 1'b0;
            f1_lvl_q   <= 1'b1;
            f2_lvl_q   <= 1'b1;
        end else begin
            pls_sync_q <= {pls_sync_q[1:0], cycle_timing_pulse};
            f1_sync_q  <= {f1_sync_q[1:0], flag_input_one_n};
            f2_sync_q  <= {f2_sync_q[1:0], flag_input_two_n};
            pls_lvl_q  <= pls_lvl_d;
            f1_lvl_q   <= f1_lvl_d;
            f2_lvl_q   <= f2_lvl_d;
        end
    end

    logic pls_rise, f1_fall, f1_rise, f2_fall, f2_rise;
    assign pls_rise = pls_lvl_d & ~pls_lvl_q;
    assign f1_fall  = ~f1_lvl_d & f1_lvl_q;
    assign f1_rise  = f1_lvl_d & ~f1_lvl_q;
    assign f2_fall  = ~f2_lvl_d & f2_lvl_q;
    assign f2_rise  = f2_lvl_d & ~f2_lvl_q;

    // flags pass straight on for branch tests, whatever the mode
    assign flag_one_level = f1_lvl_q;
    assign flag_two_level = f2_lvl_q;

    // ==================================================================
    // apb slave: zero wait states, unmapped addresses answer with pslverr
    logic        access, wr_access, rd_setup, mapped;
    logic [31:0] prdata_d, prdata_q;
    ctc_pkg::ctc_cmd_type cmd;

    assign access    = psel & penable;
    assign wr_access = access & pwrite;
    assign rd_setup  = psel & ~penable & ~pwrite;
    assign mapped    = (paddr == ctc_pkg::ADDR_COUNT) || (paddr == ctc_pkg::ADDR_CTRL)
                    || (paddr == ctc_pkg::ADDR_STATUS) || (paddr == ctc_pkg::ADDR_BUFFER);
    assign pready    = 1'b1;
    assign pslverr   = access & ~mapped;
    assign prdata    = prdata_q;

    // one write cycle decodes into one-cycle command strobes
    always_comb begin
        cmd         = '0;
        cmd.data    = pwdata[7:0];
        cmd.mode    = ctc_pkg::MODE_IDLE;
        if (wr_access && paddr == ctc_pkg::ADDR_COUNT) begin
            cmd.load = 1'b1;
        end
        if (wr_access && paddr == ctc_pkg::ADDR_CTRL) begin
            cmd.stop    = pwdata[ctc_pkg::CTRL_STOP_BIT];
            cmd.dec     = pwdata[ctc_pkg::CTRL_DEC_BIT];
            cmd.tog_on  = pwdata[ctc_pkg::CTRL_TOG_ON_BIT];
            cmd.tog_off = pwdata[ctc_pkg::CTRL_TOG_OFF_BIT];
            cmd.mode_wr = 1'b1;
            if (pwdata[ctc_pkg::CTRL_MODE_LSB +: 3] <= 3'h5) begin
                cmd.mode = ctc_pkg::ctc_mode_type'(pwdata[ctc_pkg::CTRL_MODE_LSB +: 3]);
            end
        end
        if (wr_access && paddr == ctc_pkg::ADDR_STATUS) begin
            cmd.irq_clr = pwdata[ctc_pkg::STATUS_IRQ_BIT];
        end
    end

    // ==================================================================
    // counter core
    logic [7:0]            cnt_q, cnt_d, buf_q, buf_d;
    logic [4:0]            presc_q, presc_d;
    ctc_pkg::ctc_mode_type mode_q, mode_d;
    logic                  irq_q, irq_d, tog_en_q, tog_en_d, q_q, q_d;
    logic                  mode_ev, count_ev, terminal, pw_end, irq_set;

    always_comb begin
        unique case (mode_q)
            ctc_pkg::MODE_EVENT_ONE: mode_ev = f1_fall;
            ctc_pkg::MODE_EVENT_TWO: mode_ev = f2_fall;
            ctc_pkg::MODE_TIMER:     mode_ev = pls_rise && presc_q == ctc_pkg::PRESC_END;
            ctc_pkg::MODE_PULSE_ONE: mode_ev = pls_rise && !f1_lvl_q;
            ctc_pkg::MODE_PULSE_TWO: mode_ev = pls_rise && !f2_lvl_q;
            default:                 mode_ev = 1'b0;
        endcase
        pw_end = (mode_q == ctc_pkg::MODE_PULSE_ONE && f1_rise)
              || (mode_q == ctc_pkg::MODE_PULSE_TWO && f2_rise);
        // software decrement may collide with a mode event; software avoids it
        count_ev = (mode_ev | cmd.dec) & ~cmd.load;
        terminal = count_ev && cnt_q == ctc_pkg::COUNT_ONE;
        // underflow in pulse modes sets the flag but leaves the mode running
        irq_set  = terminal | pw_end;
    end

    always_comb begin
        cnt_d    = cnt_q;
        buf_d    = buf_q;
        mode_d   = mode_q;
        presc_d  = presc_q;
        tog_en_d = tog_en_q;
        q_d      = q_q;
        // reload from buffer at 01; 00 simply wraps, giving 256 counts
        if (cmd.load) begin
            cnt_d = cmd.data;
            buf_d = cmd.data;
        end else if (terminal) begin
            cnt_d = buf_q;
        end else if (count_ev) begin
            cnt_d = cnt_q - 8'h01;
        end
        if (cmd.mode_wr) begin
            mode_d = cmd.mode;
        end
        if (cmd.stop || pw_end) begin
            mode_d = ctc_pkg::MODE_IDLE;
        end
        if (mode_q != ctc_pkg::MODE_TIMER || mode_d != ctc_pkg::MODE_TIMER) begin
            presc_d = ctc_pkg::PRESC_RST;
        end else if (pls_rise) begin
            presc_d = presc_q - 5'h01;
        end
        if (cmd.tog_on) begin
            tog_en_d = 1'b1;
        end else if (cmd.tog_off) begin
            tog_en_d = 1'b0;
        end
        if (terminal && tog_en_q) begin
            q_d = ~q_q;
        end
        // a set in the clearing cycle wins
        irq_d = (irq_q & ~cmd.load & ~cmd.irq_clr) | irq_set;
    end

    // reads only capture data; no state above looks at rd_setup
    always_comb begin
        prdata_d = prdata_q;
        if (rd_setup) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                ctc_pkg::ADDR_COUNT:  prdata_d[7:0] = cnt_q;
                ctc_pkg::ADDR_CTRL: begin
                    prdata_d[ctc_pkg::CTRL_MODE_LSB +: 3]  = mode_q;
                    prdata_d[ctc_pkg::CTRL_TOG_RD_BIT]     = tog_en_q;
                end
                ctc_pkg::ADDR_STATUS: begin
                    prdata_d[ctc_pkg::STATUS_IRQ_BIT]      = irq_q;
                    prdata_d[ctc_pkg::STATUS_PRE_LSB +: 5] = presc_q;
                end
                ctc_pkg::ADDR_BUFFER: prdata_d[7:0] = buf_q;
                default:              prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= ctc_pkg::COUNT_RST;
            buf_q    <= ctc_pkg::COUNT_RST;
            presc_q  <= ctc_pkg::PRESC_RST;
            mode_q   <= ctc_pkg::MODE_IDLE;
            irq_q    <= 1'b0;
            tog_en_q <= 1'b0;
            q_q      <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            cnt_q    <= cnt_d;
            buf_q    <= buf_d;
            presc_q  <= presc_d;
            mode_q   <= mode_d;
            irq_q    <= irq_d;
            tog_en_q <= tog_en_d;
            q_q      <= q_d;
            prdata_q <= prdata_d;
        end
    end

    assign counter_irq = irq_q;
    assign q_out       = q_q;

    // ==================================================================
    // assertions
    a_load_both_regs: assert property (@(posedge pclk) disable iff (!presetn)
        cmd.load |=> cnt_q == $past(pwdata[7:0]) && buf_q == $past(pwdata[7:0]))
        else $error("load did not reach counter and buffer");

    a_load_clears_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd.load && !pw_end) |=> !irq_q)
        else $error("load left interrupt pending");

    a_reload_at_one: assert property (@(posedge pclk) disable iff (!presetn)
        (count_ev && cnt_q == 8'h01) |=> cnt_q == $past(buf_q) && irq_q)
        else $error("no reload or interrupt at terminal count");

    a_zero_full_span: assert property (@(posedge pclk) disable iff (!presetn)
        (count_ev && cnt_q == 8'h00 && !pw_end && !cmd.irq_clr)
        |=> cnt_q == 8'hff && irq_q == $past(irq_q))
        else $error("zero preset did not wrap to ff");

    a_presc_held: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q != ctc_pkg::MODE_TIMER) |=> presc_q == 5'h1f)
        else $error("prescaler ran outside timer mode");

    a_timer_no_early: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_TIMER && presc_q != 5'h00 && !cmd.dec && !cmd.load)
        |=> cnt_q == $past(cnt_q))
        else $error("timer counted before prescaler wrap");

    a_event_one_dec: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_EVENT_ONE && f1_fall && cnt_q > 8'h01 && !cmd.load && !cmd.dec)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("flag one fall did not decrement");

    a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_PULSE_ONE && f1_rise) |=> mode_q == ctc_pkg::MODE_IDLE && irq_q)
        else $error("pulse end did not halt and flag");

    a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
        cmd.stop |=> mode_q == ctc_pkg::MODE_IDLE ##1 (!mode_ev || cmd.mode_wr))
        else $error("stop left a mode active");

    a_read_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && !count_ev && !pw_end && !cmd.load)
        |=> cnt_q == $past(cnt_q) && mode_q == $past(mode_q) && irq_q == $past(irq_q))
        else $error("read disturbed counter state");

    a_toggle_q: assert property (@(posedge pclk) disable iff (!presetn)
        (count_ev && cnt_q == 8'h01 && tog_en_q) |=> q_out != $past(q_out))
        else $error("q did not toggle at terminal count");

    a_event_two_dec: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_EVENT_TWO && f2_fall && cnt_q > 8'h01 && !cmd.load && !cmd.dec)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("flag two fall did not decrement");

    a_pulse_two_end: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_PULSE_TWO && f2_rise) |=> mode_q == ctc_pkg::MODE_IDLE && irq_q)
        else $error("pulse two end did not halt and flag");

    a_pulse_gate_one: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == ctc_pkg::MODE_PULSE_ONE && f1_lvl_q && !cmd.dec && !cmd.load)
        |=> cnt_q == $past(cnt_q))
        else $error("pulse mode counted with flag one high");

endmodule : ctc_timer_counter

// >>> verif/ctc_far_side.sv
`timescale 1ns/1ps
// ==========================================================
// board side: pulled-up flag pins and the cycle timing pulse
module ctc_far_side (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pulse_run,
    input  wire logic one_low,
    input  wire logic two_low,
    output logic      cycle_timing_pulse,
    output logic      flag_input_one_n,
    output logic      flag_input_two_n,
    output int        rises
);
    logic [2:0] ph_q;
    // flags idle high through the pull-ups; driver holds each level 8 clocks
    assign flag_input_one_n   = !one_low;
    assign flag_input_two_n   = !two_low;
    // a started pulse always finishes, so no runt edge reaches the pin
    assign cycle_timing_pulse = ph_q[2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q  <= 3'h0;
            rises <= 0;
        end else if (pulse_run || ph_q != 3'h0) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h3) rises <= rises + 1;
        end
    end
endmodule : ctc_far_side

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, ld;
    logic [31:0] pwdata, prdata;
    logic        pulse, f1_n, f2_n, f1_lvl, f2_lvl, irq, q_out, pulse_run, one_low, two_low;
    int          rises, err_total, comparisons, cycles;
    logic [32:0] exp_q[$];

    ctc_timer_counter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_timing_pulse(pulse), .flag_input_one_n(f1_n),
        .flag_input_two_n(f2_n), .flag_one_level(f1_lvl), .flag_two_level(f2_lvl),
        .counter_irq(irq), .q_out(q_out));
    ctc_far_side far (.pclk(pclk), .presetn(presetn), .pulse_run(pulse_run), .one_low(one_low),
        .two_low(two_low), .cycle_timing_pulse(pulse), .flag_input_one_n(f1_n),
        .flag_input_two_n(f2_n), .rises(rises));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================================
    // checking and closing
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // read results: {pslverr, prdata} against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
            check("read", {pslverr, prdata}, exp_q.pop_front());
    end

    // hang guard; the longest path needs about 6000 clocks
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    // ==========================================================
    // apb master and pin drivers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic flag(input int which, input logic low);
        @(posedge pclk);
        if (which == 1) one_low <= low;
        else two_low <= low;
        repeat (8) @(posedge pclk);
        check("flag level", {32'h0, which == 1 ? f1_lvl : f2_lvl}, {32'h0, !low});
    endtask : flag

    task automatic tick(input int n);
        int t;
        t = rises + n;
        @(posedge pclk);
        pulse_run <= 1'b1;
        while (rises < t) @(posedge pclk);
        pulse_run <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask : tick

    // ==========================================================
    // tests
    initial begin
        {presetn, psel, penable, pwrite, pulse_run, one_low, two_low} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        {err_total, comparisons, cycles} = 96'h0;
        void'($urandom(32'h703a));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ctc_pkg::ADDR_COUNT, 33'h0);
        rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
        rd(8'h10, 33'h100000000);
        $display("test reset done");
        for (int k = 1; k <= 2; k++) begin
            wr(ctc_pkg::ADDR_CTRL, 32'h10); // stop before any load
            ld = 8'($urandom_range(9, 2));
            wr(ctc_pkg::ADDR_COUNT, {24'h0, ld});
            wr(ctc_pkg::ADDR_CTRL, 32'h40 + 32'(k));
            flag(3 - k, 1'b1);
            flag(3 - k, 1'b0);
            for (int e = 1; e < ld; e++) begin
                flag(k, 1'b1);
                flag(k, 1'b0);
            end
            rd(ctc_pkg::ADDR_COUNT, 33'h1);
            rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
            flag(k, 1'b1);
            flag(k, 1'b0);
            rd(ctc_pkg::ADDR_COUNT, {25'h0, ld});
            rd(ctc_pkg::ADDR_STATUS, 33'h1f01);
            check("toggle", {32'h0, q_out}, {32'h0, k == 1});
            check("irq pin", {32'h0, irq}, 33'h1);
            rd(ctc_pkg::ADDR_BUFFER, {25'h0, ld});
            rd(ctc_pkg::ADDR_CTRL, 33'h100 + 33'(k));
            wr(ctc_pkg::ADDR_CTRL, 32'h10);
            wr(ctc_pkg::ADDR_COUNT, {24'h0, ld});
            rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
            check("irq pin", {32'h0, irq}, 33'h0);
            $display("test event mode %0d done", k);
        end
        wr(ctc_pkg::ADDR_COUNT, 32'h2);
        wr(ctc_pkg::ADDR_CTRL, 32'h3);
        tick(31);
        rd(ctc_pkg::ADDR_COUNT, 33'h2);
        rd(ctc_pkg::ADDR_STATUS, 33'h0);
        tick(1);
        rd(ctc_pkg::ADDR_COUNT, 33'h1);
        wr(ctc_pkg::ADDR_CTRL, 32'h10);
        rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
        tick(32);
        rd(ctc_pkg::ADDR_COUNT, 33'h1);
        wr(ctc_pkg::ADDR_CTRL, 32'h20); // decrement only while stopped
        rd(ctc_pkg::ADDR_COUNT, 33'h2);
        rd(ctc_pkg::ADDR_STATUS, 33'h1f01);
        check("toggle", {32'h0, q_out}, 33'h1);
        $display("test timer and software count done");
        for (int k = 1; k <= 2; k++) begin
            wr(ctc_pkg::ADDR_CTRL, 32'h90);
            wr(ctc_pkg::ADDR_COUNT, 32'h0);
            wr(ctc_pkg::ADDR_CTRL, 32'h3 + 32'(k));
            tick(2);
            rd(ctc_pkg::ADDR_COUNT, 33'h0);
            flag(k, 1'b1);
            tick(255);
            rd(ctc_pkg::ADDR_COUNT, 33'h1);
            rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
            tick(1);
            rd(ctc_pkg::ADDR_COUNT, 33'h0);
            rd(ctc_pkg::ADDR_STATUS, 33'h1f01);
            check("toggle off", {32'h0, q_out}, 33'h1);
            tick(2);
            rd(ctc_pkg::ADDR_COUNT, 33'hfe);
            flag(k, 1'b0);
            rd(ctc_pkg::ADDR_CTRL, 33'h0);
            rd(ctc_pkg::ADDR_STATUS, 33'h1f01);
            check("irq pin", {32'h0, irq}, 33'h1);
            tick(2);
            rd(ctc_pkg::ADDR_COUNT, 33'hfe);
            wr(ctc_pkg::ADDR_STATUS, 32'h1);
            rd(ctc_pkg::ADDR_STATUS, 33'h1f00);
            $display("test pulse mode %0d done", k);
        end
        wr(ctc_pkg::ADDR_CTRL, 32'h47);
        rd(ctc_pkg::ADDR_CTRL, 33'h100);
        $display("test mode decode done");
        close_out();
    end
endmodule : tb
